// *** setpoint_pkg.sv ***
package setpoint_pkg;
  // Fixed-point widths and clock
  localparam int SPEED_W = 16;
  localparam int CLK_HZ = 10_000_000;
  localparam int RAMP_W = 32;
  // Register word offsets
  localparam logic [5:0] OFS_CONFIG = 6'h00;
  localparam logic [5:0] OFS_START = 6'h01;
  localparam logic [5:0] OFS_RISE = 6'h02;
  localparam logic [5:0] OFS_FALL = 6'h03;
  localparam logic [5:0] OFS_UPPER = 6'h04;
  localparam logic [5:0] OFS_LOWER = 6'h05;
  localparam logic [5:0] OFS_SETVAL = 6'h06;
  localparam logic [5:0] OFS_CTRL = 6'h07;
  localparam logic [5:0] OFS_MAIN_SRC = 6'h08;
  localparam logic [5:0] OFS_ADD_SRC = 6'h09;
  localparam logic [5:0] OFS_FIXMODE = 6'h0A;
  localparam logic [5:0] OFS_POT_OUT = 6'h0B;
  localparam logic [5:0] OFS_MAIN_OUT = 6'h0C;
  localparam logic [5:0] OFS_ADD_OUT = 6'h0D;
  localparam logic [5:0] OFS_SAVED = 6'h0E;
  localparam logic [5:0] OFS_FIXED0 = 6'h10;
  // Configuration field bits
  localparam int CFG_SAVE_BIT = 0;
  localparam int CFG_AUTORAMP_BIT = 1;
  localparam int CFG_ROUND_BIT = 2;
  localparam int CFG_NV_BIT = 3;
  localparam int CFG_ALWAYS_BIT = 4;
  localparam logic [4:0] CFG_RESET = 5'b00110;
  // Control register bits
  localparam int CTRL_SETVAL_SEL_BIT = 0;
  // Reset values
  localparam logic [SPEED_W-1:0] START_RESET = 16'h0000;
  localparam logic [SPEED_W-1:0] LIMIT_RESET = 16'h0000;
  localparam logic [SPEED_W-1:0] SETVAL_RESET = 16'h0000;
  localparam logic [15:0] RAMP_TIME_RESET_S = 16'h000A;
  localparam logic [1:0] FIXMODE_DIRECT = 2'h1;
  localparam logic [1:0] FIXMODE_BINARY = 2'h2;
  // Rounding phase length in milliseconds and cycles
  localparam int ROUND_MS = 100;
  localparam int ROUND_CYCLES = ROUND_MS * (CLK_HZ / 1000);
  // Setpoint sources
  typedef enum logic [1:0] {
    SRC_NONE = 2'b00,
    SRC_FIELDBUS = 2'b01,
    SRC_POT = 2'b10,
    SRC_FIXED = 2'b11
  } source_t;
endpackage

// *** fixed_bus_if.sv ***
`timescale 1ns/1ps
interface fixed_bus_if;
  import setpoint_pkg::*;
  logic direct_mode;
  logic [3:0] select_bits;
  logic [SPEED_W-1:0] table_data [16];
  logic [SPEED_W-1:0] result;
  modport owner (output direct_mode, output select_bits, output table_data, input result);
  modport selector (input direct_mode, input select_bits, input table_data, output result);
endinterface // fixed_bus_if

// *** fixed_speed_select.sv ***
`timescale 1ns/1ps
module fixed_speed_select
  import setpoint_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  fixed_bus_if.selector fb
);
  logic [SPEED_W-1:0] result;
  logic [SPEED_W-1:0] next_result;
  logic [SPEED_W-1:0] direct_sum;

  // Direct mode sums the first four speeds whose bits are set
  // direct sum
  always_comb begin
    direct_sum = '0;
    for (int i = 0; i < 4; i++) begin
      if (fb.select_bits[i]) begin
        direct_sum = direct_sum + fb.table_data[i];
      end
    end
  end

  // Binary mode indexes one of sixteen; bit 0 is least significant
  // mode and index
  always_comb begin
    next_result = fb.direct_mode ? direct_sum : fb.table_data[fb.select_bits];
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      result <= '0;
    end else begin
      result <= next_result;
    end
  end
  assign fb.result = result;

  a_binary_pick: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !fb.direct_mode |=> result == $past(fb.table_data[fb.select_bits])) else $error("binary pick wrong");
  a_direct_none: assert property (@(posedge ref_clk) disable iff (!rst_n)
    fb.direct_mode && fb.select_bits == 4'h0 |=> result == 16'h0000) else $error("direct zero wrong");
endmodule // fixed_speed_select

// *** speed_setpoint_source_select.sv ***
`timescale 1ns/1ps
// Behaviour
// - Main and additional selectors may take fieldbus word two as source.
// - Potentiometer rises while raise active, falls while lower active.
// - Separate rise and fall times set ramp rates, both default ten seconds.
// - Programmable start value, default zero, loaded at first switch-on; here only with config and control bit 0 clear, else saved or setting value.
// - Config bit 0 clear restarts from start; set keeps value across switch-off.
// - Bit 1 picks ramp or jump in automatic mode; manual always ramps.
// - Bit 2 enables initial rounding so small changes can be entered.
// - Bits 3 and 0 set keep the value across power failure; here reset clears it unless the host writes it back via OFS_SAVED.
// - Bit 4 clear updates only with pulses enabled; set always updates.
// - Configuration field resets to 00110 binary.
// - Setting value from a selectable source, default zero.
// - Raise and lower command inputs, default inactive.
// - Main and additional each take potentiometer or fixed result.
// - Up to sixteen fixed-speed results chosen by the controller.
// - Direct mode sums the four fixed speeds whose bits are active.
// - Binary mode outputs exactly one of sixteen fixed speeds.
// - Mode setting one selects direct; speeds in rpm, bits routable.
module speed_setpoint_source_select
  import setpoint_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [5:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic [SPEED_W-1:0] fieldbus_word2,
  input wire logic [SPEED_W-1:0] setting_signal,
  input wire logic pot_raise_cmd,
  input wire logic pot_lower_cmd,
  input wire logic pot_auto_manual_select,
  input wire logic motor_on_off_cmd,
  input wire logic pulse_enable,
  input wire logic [3:0] fixed_select_pins,
  output logic [SPEED_W-1:0] main_setpoint,
  output logic [SPEED_W-1:0] additional_setpoint
);
  // Command pins are asynchronous: two flip-flops before any use
  logic [8:0] pin_meta;
  logic [8:0] pin_sync;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_meta <= '0;
      pin_sync <= '0;
    end else begin
      pin_meta <= {pulse_enable, motor_on_off_cmd, pot_auto_manual_select, pot_lower_cmd, pot_raise_cmd,
                   fixed_select_pins};
      pin_sync <= pin_meta;
    end
  end
  logic raise_s, lower_s, auto_s, on_s, pulse_s;
  logic [3:0] fsel_s;
  assign {pulse_s, on_s, auto_s, lower_s, raise_s, fsel_s} = pin_sync;

  // Fieldbus word and setting source are buses from other clocked logic; registered twice too
  logic [SPEED_W-1:0] fb_meta, fb_word, set_meta, set_sig;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      fb_meta <= '0;
      fb_word <= '0;
      set_meta <= '0;
      set_sig <= '0;
    end else begin
      fb_meta <= fieldbus_word2;
      fb_word <= fb_meta;
      set_meta <= setting_signal;
      set_sig <= set_meta;
    end
  end

  // Register file
  logic [4:0] pot_config, next_pot_config;
  logic [SPEED_W-1:0] pot_start_value, next_pot_start_value;
  logic [15:0] pot_rise_time, next_pot_rise_time;
  logic [15:0] pot_fall_time, next_pot_fall_time;
  logic [SPEED_W-1:0] pot_upper_limit, next_pot_upper_limit;
  logic [SPEED_W-1:0] pot_lower_limit, next_pot_lower_limit;
  logic [SPEED_W-1:0] pot_setting_value, next_pot_setting_value;
  logic [0:0] ctrl, next_ctrl;
  logic [1:0] main_setpoint_source, next_main_setpoint_source;
  logic [1:0] additional_setpoint_source, next_additional_setpoint_source;
  logic [1:0] fixed_speed_select_mode, next_fixed_speed_select_mode;
  logic [SPEED_W-1:0] fixed_speed [16];
  logic [SPEED_W-1:0] next_fixed_speed [16];
  logic [SPEED_W-1:0] pot_out;
  logic [SPEED_W-1:0] saved_value;
  logic [31:0] next_reg_rdata;
  logic [SPEED_W-1:0] fixed_result;

  // Register writes; the store for the held value lives with the ramp state
  always_comb begin
    next_pot_config = pot_config;
    next_pot_start_value = pot_start_value;
    next_pot_rise_time = pot_rise_time;
    next_pot_fall_time = pot_fall_time;
    next_pot_upper_limit = pot_upper_limit;
    next_pot_lower_limit = pot_lower_limit;
    next_pot_setting_value = pot_setting_value;
    next_ctrl = ctrl;
    next_main_setpoint_source = main_setpoint_source;
    next_additional_setpoint_source = additional_setpoint_source;
    next_fixed_speed_select_mode = fixed_speed_select_mode;
    next_fixed_speed = fixed_speed;
    if (reg_wr) begin
      unique case (reg_addr)
        OFS_CONFIG: next_pot_config = reg_wdata[4:0];
        OFS_START: next_pot_start_value = reg_wdata[SPEED_W-1:0];
        OFS_RISE: next_pot_rise_time = reg_wdata[15:0];
        OFS_FALL: next_pot_fall_time = reg_wdata[15:0];
        OFS_UPPER: next_pot_upper_limit = reg_wdata[SPEED_W-1:0];
        OFS_LOWER: next_pot_lower_limit = reg_wdata[SPEED_W-1:0];
        OFS_SETVAL: next_pot_setting_value = reg_wdata[SPEED_W-1:0];
        OFS_CTRL: next_ctrl = reg_wdata[0:0];
        OFS_MAIN_SRC: next_main_setpoint_source = reg_wdata[1:0];
        OFS_ADD_SRC: next_additional_setpoint_source = reg_wdata[1:0];
        OFS_FIXMODE: next_fixed_speed_select_mode = reg_wdata[1:0];
        default: begin
          if (reg_addr[5:4] == OFS_FIXED0[5:4]) begin
            next_fixed_speed[reg_addr[3:0]] = reg_wdata[SPEED_W-1:0];
          end
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pot_config <= CFG_RESET;
      pot_start_value <= START_RESET;
      pot_rise_time <= RAMP_TIME_RESET_S;
      pot_fall_time <= RAMP_TIME_RESET_S;
      pot_upper_limit <= LIMIT_RESET;
      pot_lower_limit <= LIMIT_RESET;
      pot_setting_value <= SETVAL_RESET;
      ctrl <= '0;
      main_setpoint_source <= SRC_NONE;
      additional_setpoint_source <= SRC_NONE;
      fixed_speed_select_mode <= FIXMODE_BINARY;
      for (int i = 0; i < 16; i++) begin
        fixed_speed[i] <= '0;
      end
    end else begin
      pot_config <= next_pot_config;
      pot_start_value <= next_pot_start_value;
      pot_rise_time <= next_pot_rise_time;
      pot_fall_time <= next_pot_fall_time;
      pot_upper_limit <= next_pot_upper_limit;
      pot_lower_limit <= next_pot_lower_limit;
      pot_setting_value <= next_pot_setting_value;
      ctrl <= next_ctrl;
      main_setpoint_source <= next_main_setpoint_source;
      additional_setpoint_source <= next_additional_setpoint_source;
      fixed_speed_select_mode <= next_fixed_speed_select_mode;
      fixed_speed <= next_fixed_speed;
    end
  end

  // Ramp potentiometer: one rpm step each time the accumulator reaches twice the step period
  logic [RAMP_W-1:0] acc, next_acc;
  logic [RAMP_W-1:0] round_cnt, next_round_cnt;
  logic [SPEED_W-1:0] next_pot_out, next_saved_value;
  logic on_d, next_on_d;
  logic [RAMP_W-1:0] step_period;
  logic ramp_on, update_ok, moving;
  logic [SPEED_W-1:0] target;

  always_comb begin
    // Rate: limit span per ramp time, so step period = time * clock / span
    // separate rates
    step_period = RAMP_W'(((raise_s ? pot_rise_time : pot_fall_time) * CLK_HZ)
                  / ((pot_upper_limit > pot_lower_limit ? pot_upper_limit - pot_lower_limit : 16'h0001) + 16'h0000));
    ramp_on = !auto_s || pot_config[CFG_AUTORAMP_BIT];
    update_ok = pot_config[CFG_ALWAYS_BIT] || pulse_s;
    moving = raise_s ^ lower_s;
    target = raise_s ? pot_upper_limit : pot_lower_limit;
  end

  always_comb begin
    next_acc = acc;
    next_round_cnt = round_cnt;
    next_pot_out = pot_out;
    next_saved_value = saved_value;
    next_on_d = on_s;
    if (on_s && !on_d) begin
      if (pot_config[CFG_SAVE_BIT]) begin
        next_pot_out = saved_value;
      end else if (ctrl[CTRL_SETVAL_SEL_BIT]) begin
        next_pot_out = set_sig;
      end else begin
        next_pot_out = pot_start_value;
      end
      next_acc = '0;
      next_round_cnt = '0;
    end else if (!on_s && on_d) begin
      next_saved_value = pot_out;
    end else if (update_ok && moving && pot_out != target) begin
      if (!ramp_on) begin
        next_pot_out = target;
      end else begin
        // initial rounding: half rate during first phase
        next_acc = acc + ((pot_config[CFG_ROUND_BIT] && round_cnt < RAMP_W'(ROUND_CYCLES)) ? 32'h0000_0001 :
                   32'h0000_0002);
        if (round_cnt < RAMP_W'(ROUND_CYCLES)) begin
          next_round_cnt = round_cnt + 32'h0000_0001;
        end
        if (next_acc >= {step_period[RAMP_W-2:0], 1'b0}) begin
          next_acc = '0;
          next_pot_out = raise_s ? pot_out + 16'h0001 : pot_out - 16'h0001;
        end
      end
    end else if (!moving) begin
      next_acc = '0;
      next_round_cnt = '0;
    end
    if (next_pot_out > pot_upper_limit) begin
      next_pot_out = pot_upper_limit;
    end
    if (next_pot_out < pot_lower_limit) begin
      next_pot_out = pot_lower_limit;
    end
  end

  // Saved value is plain flops; kept across power loss only when the host backs it up from OFS_SAVED
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      acc <= '0;
      round_cnt <= '0;
      pot_out <= '0;
      saved_value <= '0;
      on_d <= 1'b0;
    end else begin
      acc <= next_acc;
      round_cnt <= next_round_cnt;
      pot_out <= next_pot_out;
      saved_value <= (reg_wr && reg_addr == OFS_SAVED && pot_config[CFG_NV_BIT]) ? reg_wdata[SPEED_W-1:0] :
                     next_saved_value;
      on_d <= next_on_d;
    end
  end

  // Fixed speed selector
  fixed_bus_if fbi ();
  assign fbi.direct_mode = (fixed_speed_select_mode == FIXMODE_DIRECT);
  assign fbi.select_bits = fsel_s;
  assign fbi.table_data = fixed_speed;
  assign fixed_result = fbi.result;
  fixed_speed_select u_fixed (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .fb(fbi.selector)
  );

  // Source routing
  logic [SPEED_W-1:0] next_main, next_add;
  function automatic logic [SPEED_W-1:0] route(input logic [1:0] s, input logic [SPEED_W-1:0] f,
                                              input logic [SPEED_W-1:0] p, input logic [SPEED_W-1:0] x);
    unique case (s)
      SRC_FIELDBUS: route = f;
      SRC_POT: route = p;
      SRC_FIXED: route = x;
      SRC_NONE: route = '0;
    endcase
  endfunction
  always_comb begin
    next_main = route(main_setpoint_source, fb_word, pot_out, fixed_result);
    next_add = route(additional_setpoint_source, fb_word, pot_out, fixed_result);
    next_reg_rdata = '0;
    if (reg_rd) begin
      unique case (reg_addr)
        OFS_CONFIG: next_reg_rdata = {27'h0, pot_config};
        OFS_START: next_reg_rdata = {16'h0, pot_start_value};
        OFS_RISE: next_reg_rdata = {16'h0, pot_rise_time};
        OFS_FALL: next_reg_rdata = {16'h0, pot_fall_time};
        OFS_UPPER: next_reg_rdata = {16'h0, pot_upper_limit};
        OFS_LOWER: next_reg_rdata = {16'h0, pot_lower_limit};
        OFS_SETVAL: next_reg_rdata = {16'h0, pot_setting_value};
        OFS_CTRL: next_reg_rdata = {31'h0, ctrl};
        OFS_MAIN_SRC: next_reg_rdata = {30'h0, main_setpoint_source};
        OFS_ADD_SRC: next_reg_rdata = {30'h0, additional_setpoint_source};
        OFS_FIXMODE: next_reg_rdata = {30'h0, fixed_speed_select_mode};
        OFS_POT_OUT: next_reg_rdata = {16'h0, pot_out};
        OFS_MAIN_OUT: next_reg_rdata = {16'h0, main_setpoint};
        OFS_ADD_OUT: next_reg_rdata = {16'h0, additional_setpoint};
        OFS_SAVED: next_reg_rdata = {16'h0, saved_value};
        default: begin
          if (reg_addr[5:4] == OFS_FIXED0[5:4]) begin
            next_reg_rdata = {16'h0, fixed_speed[reg_addr[3:0]]};
          end
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      main_setpoint <= '0;
      additional_setpoint <= '0;
      reg_rdata <= '0;
    end else begin
      main_setpoint <= next_main;
      additional_setpoint <= next_add;
      reg_rdata <= next_reg_rdata;
    end
  end

  a_pot_bounded: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ##1 (pot_out <= $past(pot_upper_limit) || pot_out <= $past(pot_lower_limit))) else $error("pot above limit");
  a_pulse_gate: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !pot_config[CFG_ALWAYS_BIT] && !pulse_s && on_s && on_d |=> $stable(pot_out)) else $error("pot moved gated");
  a_start_load: assert property (@(posedge ref_clk) disable iff (!rst_n)
    on_s && !on_d && pot_config == 5'b00000 && !ctrl[0] && pot_start_value <= pot_upper_limit
    && pot_start_value >= pot_lower_limit |=> pot_out == $past(pot_start_value)) else $error("start not loaded");
  a_keep_off: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !on_s && on_d |=> saved_value == $past(pot_out)) else $error("value not saved");
  a_jump_auto: assert property (@(posedge ref_clk) disable iff (!rst_n)
    auto_s && !pot_config[CFG_AUTORAMP_BIT] && pulse_s && on_s && on_d && raise_s && !lower_s
    |=> pot_out == $past(pot_upper_limit)) else $error("no jump in auto");
  a_main_route: assert property (@(posedge ref_clk) disable iff (!rst_n)
    main_setpoint_source == SRC_POT |=> main_setpoint == $past(pot_out)) else $error("main route wrong");
endmodule // speed_setpoint_source_select

// *** controller_model.sv ***
`timescale 1ns/1ps
// Higher-level controller on the far side: drives pins and fieldbus words
module controller_model
  import setpoint_pkg::*;
(
  input wire logic ref_clk,
  output logic [SPEED_W-1:0] fieldbus_word2,
  output logic [SPEED_W-1:0] setting_signal,
  output logic pot_raise_cmd,
  output logic pot_lower_cmd,
  output logic pot_auto_manual_select,
  output logic motor_on_off_cmd,
  output logic pulse_enable,
  output logic [3:0] fixed_select_pins
);
  // Commands start inactive so nothing moves before the bench asks
  initial begin
    fieldbus_word2 = 16'h0000;
    setting_signal = 16'h0000;
    {pot_raise_cmd, pot_lower_cmd, pot_auto_manual_select, motor_on_off_cmd, pulse_enable} = 5'h00;
    fixed_select_pins = 4'h0;
  end
  task automatic send_word(input logic [SPEED_W-1:0] w);
    @(posedge ref_clk);
    fieldbus_word2 <= w;
  endtask
  // Order: raise, lower, auto, motor on, pulse enable
  task automatic drive_pins(input logic [4:0] lvl);
    @(posedge ref_clk);
    {pot_raise_cmd, pot_lower_cmd, pot_auto_manual_select, motor_on_off_cmd, pulse_enable} <= lvl;
  endtask
  task automatic select_fixed(input logic [3:0] s);
    @(posedge ref_clk);
    fixed_select_pins <= s;
  endtask
  task automatic send_setting(input logic [SPEED_W-1:0] w);
    @(posedge ref_clk);
    setting_signal <= w;
  endtask
endmodule // controller_model

// *** speed_setpoint_source_select_bench.sv ***
`timescale 1ns/1ps
module speed_setpoint_source_select_bench;
  import setpoint_pkg::*;
  logic ref_clk, rst_n, reg_wr, reg_rd;
  logic [5:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, rdv;
  logic [SPEED_W-1:0] fieldbus_word2, setting_signal, main_setpoint, additional_setpoint;
  logic pot_raise_cmd, pot_lower_cmd, pot_auto_manual_select, motor_on_off_cmd, pulse_enable;
  logic [3:0] fixed_select_pins;
  int mismatches, checked, sum;
  int fix[16];
  int q[$];
  logic [5:0] rst_addr[9] = '{OFS_CONFIG, OFS_START, OFS_RISE, OFS_FALL, OFS_UPPER, OFS_LOWER, OFS_SETVAL,
    OFS_FIXMODE, 6'h0F};
  logic [31:0] rst_val[9] = '{32'h0000_0006, 32'h0000_0000, 32'h0000_000A, 32'h0000_000A, 32'h0000_0000,
    32'h0000_0000, 32'h0000_0000, 32'h0000_0002, 32'h0000_0000};

  speed_setpoint_source_select i_speed_setpoint_source_select (.ref_clk(ref_clk), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .fieldbus_word2(fieldbus_word2), .setting_signal(setting_signal), .pot_raise_cmd(pot_raise_cmd),
    .pot_lower_cmd(pot_lower_cmd), .pot_auto_manual_select(pot_auto_manual_select),
    .motor_on_off_cmd(motor_on_off_cmd), .pulse_enable(pulse_enable), .fixed_select_pins(fixed_select_pins),
    .main_setpoint(main_setpoint), .additional_setpoint(additional_setpoint));
  controller_model i_controller_model (.ref_clk(ref_clk), .fieldbus_word2(fieldbus_word2),
    .setting_signal(setting_signal), .pot_raise_cmd(pot_raise_cmd), .pot_lower_cmd(pot_lower_cmd),
    .pot_auto_manual_select(pot_auto_manual_select), .motor_on_off_cmd(motor_on_off_cmd),
    .pulse_enable(pulse_enable), .fixed_select_pins(fixed_select_pins));

  // 10 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic complete_run();
    if (mismatches == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // One-cycle strobes; an idle edge between accesses keeps each strobe assigned once per step
  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= {16'h0000, d};
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [5:0] a);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    rdv = reg_rdata;
  endtask
  // Pins cross two flops, so allow settling before looking
  task automatic settle();
    repeat (8) @(posedge ref_clk);
    #1;
  endtask
  // Bounded poll of the potentiometer output
  task automatic poll_pot(input logic [15:0] exp);
    for (int n = 0; n < 40; n++) begin
      rd(OFS_POT_OUT);
      if (rdv === {16'h0000, exp}) break;
    end
    check("pot_out", rdv, {16'h0000, exp});
  endtask
  task automatic power_cycle(input logic [4:0] lvl);
    i_controller_model.drive_pins(lvl & 5'b00101);
    settle();
    i_controller_model.drive_pins(lvl);
    settle();
  endtask

  // Watchdog sized well above the expected run
  initial begin
    repeat (60000) @(posedge ref_clk);
    mismatches++;
    complete_run();
  end

  initial begin
    {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    rst_n = 1'b0;
    void'($urandom(32'hf669));
    repeat (6) @(posedge ref_clk);
    rst_n <= 1'b1;
    // Reset values, including an unmapped word
    for (int i = 0; i < 9; i++) begin
      rd(rst_addr[i]);
      check("reset_value", rdv, rst_val[i]);
    end
    wr(6'h0F, 16'h1234);
    rd(6'h0F);
    check("unmapped", rdv, 32'h0000_0000);
    // Fieldbus word to both selectors
    wr(OFS_MAIN_SRC, 16'h0001);
    wr(OFS_ADD_SRC, 16'h0001);
    for (int k = 0; k < 4; k++) begin
      q.push_back($urandom & 16'hFFFF);
      // Command pins wander meanwhile; zero limits keep the potentiometer at zero
      i_controller_model.drive_pins(5'($urandom));
      i_controller_model.send_word(16'(q[k]));
      settle();
      check("main_fieldbus", main_setpoint, 32'(q[k]));
      check("add_fieldbus", additional_setpoint, 32'(q[k]));
    end
    // Direct mode: sum of the active four
    wr(OFS_FIXMODE, 16'(FIXMODE_DIRECT));
    wr(OFS_MAIN_SRC, 16'h0003);
    wr(OFS_ADD_SRC, 16'h0003);
    for (int i = 0; i < 4; i++) begin
      fix[i] = $urandom & 16'h3FFF;
      wr(OFS_FIXED0 + 6'(i), 16'(fix[i]));
    end
    for (int s = 0; s < 16; s++) begin
      i_controller_model.select_fixed(4'(s));
      settle();
      sum = 0;
      for (int b = 0; b < 4; b++) sum += s[b] ? fix[b] : 0;
      check("main_direct", main_setpoint, 32'(sum));
      check("add_direct", additional_setpoint, 32'(sum));
    end
    // Binary mode: one of sixteen by index
    wr(OFS_FIXMODE, 16'(FIXMODE_BINARY));
    for (int i = 0; i < 16; i++) begin
      fix[i] = $urandom & 16'hFFFF;
      wr(OFS_FIXED0 + 6'(i), 16'(fix[i]));
    end
    for (int s = 15; s >= 0; s--) begin
      i_controller_model.select_fixed(4'(s));
      settle();
      check("main_binary", main_setpoint, 32'(fix[s]));
      check("add_binary", additional_setpoint, 32'(fix[s]));
    end
    // Motor off first, so that the next switch-on is a real edge after the random pins
    i_controller_model.drive_pins(5'b00000);
    settle();
    // Potentiometer, automatic mode without ramp so moves jump to the limits
    wr(OFS_CONFIG, 16'h0000);
    wr(OFS_UPPER, 16'd300);
    wr(OFS_START, 16'd7);
    wr(OFS_MAIN_SRC, 16'h0002);
    i_controller_model.drive_pins(5'b00111);
    settle();
    poll_pot(16'd7);
    i_controller_model.drive_pins(5'b10111);
    poll_pot(16'd300);
    check("main_pot", main_setpoint, 32'd300);
    i_controller_model.drive_pins(5'b01111);
    poll_pot(16'd0);
    i_controller_model.drive_pins(5'b10111);
    poll_pot(16'd300);
    power_cycle(5'b00111);
    poll_pot(16'd7);
    wr(OFS_CONFIG, 16'h0001);
    i_controller_model.drive_pins(5'b10111);
    poll_pot(16'd300);
    power_cycle(5'b00111);
    poll_pot(16'd300);
    // No update without pulse enable unless bit 4 is set
    i_controller_model.drive_pins(5'b01110);
    settle();
    poll_pot(16'd300);
    wr(OFS_CONFIG, 16'h0011);
    poll_pot(16'd0);
    i_controller_model.drive_pins(5'b11111);
    settle();
    poll_pot(16'd0);
    // Manual mode ramps at ten seconds full scale, far from a jump
    i_controller_model.drive_pins(5'b10011);
    settle();
    rd(OFS_POT_OUT);
    check("manual_ramp", 32'(rdv < 32'd300), 32'd1);
    // Random setting value inside the limits, loaded at switch-on
    wr(OFS_CONFIG, 16'h0000);
    wr(OFS_CTRL, 16'h0001);
    sum = $urandom % 300;
    i_controller_model.send_setting(16'(sum));
    power_cycle(5'b00111);
    poll_pot(16'(sum));
    complete_run();
  end
endmodule // speed_setpoint_source_select_bench
